// ===== rtl/ewgs_regs.vh
// Constants for the data EEPROM write guard and status block.
// Assumes inclusion by the design files under rtl/.
`ifndef EWGS_REGS_VH
`define EWGS_REGS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define EWGS_ADDR_CTRL_STATUS 8'he4
`define EWGS_ADDR_DATA_IN     8'hf6
`define EWGS_CTRL_RESET       8'h00

// ----------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------
`define EWGS_BIT_FAULT        0
`define EWGS_BIT_SECVIOL      1
`define EWGS_BIT_ACCBLOCK     4
`define EWGS_BIT_WRENABLE     6
`define EWGS_BIT_BUSY         7
`define EWGS_FAIL_MASK        8'h0f

// ----------------------------------------------------------------
// Command bytes
// ----------------------------------------------------------------
`define EWGS_CMD_LOAD         8'h00
`define EWGS_CMD_UNLOCK       8'h08
`define EWGS_CMD_MAP          8'h09
`define EWGS_CMD_UNMAP        8'h0a
`define EWGS_CMD_LOCK         8'h0b
`define EWGS_CMD_CHECKSUM     8'h1d
`define EWGS_CMD_PAGE_ERASE   8'h33
`define EWGS_CMD_PROGRAM      8'h48
`define EWGS_CMD_ERASE_PROG   8'h68
`define EWGS_CMD_GLOBAL_ERASE 8'h4a
`define EWGS_WE_KEY           8'h96
`define EWGS_BLANK_BYTE       8'hff

// ----------------------------------------------------------------
// Guard bit positions in a page security byte, the code protect byte and the user config byte
// ----------------------------------------------------------------
`define EWGS_SEC_OFFCHIP_READ 0
`define EWGS_SEC_PAGE_WRITE   1
`define EWGS_SEC_RUN_ERASE    2
`define EWGS_CODE_PROTECT_BYTE_PROTECT     0
`define EWGS_USER_CONFIG_BYTE_FORCE_WE    2

`endif

// ===== rtl/ewgs_page_guard.v
// Guard decode for one data EEPROM page.
// Assumes the security byte is stable configuration.
`timescale 1ns/1ps
`include "ewgs_regs.vh"

module ewgs_page_guard (
  // Page security byte
  input  wire [7:0] pageSecurity,
  // Decoded guards
  output wire       offchipReadGuard,
  output wire       pageWriteGuard,
  output wire       runEraseGuard,
  output wire       checksumBlocked
);

  assign offchipReadGuard = pageSecurity[`EWGS_SEC_OFFCHIP_READ];
  assign pageWriteGuard   = pageSecurity[`EWGS_SEC_PAGE_WRITE];
  assign runEraseGuard    = pageSecurity[`EWGS_SEC_RUN_ERASE];
  assign checksumBlocked  = offchipReadGuard & ~pageWriteGuard;

endmodule // ewgs_page_guard

// ===== rtl/ewgs_write_guard.v
// Status, write enable lock and page guard checking for data EEPROM.
// Assumes a single-cycle SFR write/read port on the core clock.
`timescale 1ns/1ps
`include "ewgs_regs.vh"

module ewgs_write_guard #(
  parameter PAGES = 3
) (
  // Clock and reset
  input  wire                 clk,
  input  wire                 rst,
  // SFR port
  input  wire [7:0]           sfrAddr,
  input  wire                 sfrWrite,
  input  wire [7:0]           sfrWData,
  output wire [7:0]           sfrRData,
  // Address register page select
  input  wire [1:0]           pageSelect,
  // Configuration bytes
  input  wire [7:0]           userConfigByte,
  input  wire [7:0]           codeProtectByte,
  input  wire [8*PAGES-1:0]   dataPageSecurity,
  // Mode and array status
  input  wire                 inCircuitProgrammingMode,
  input  wire                 resetInterruptedOp,
  input  wire                 highVoltageError,
  input  wire                 arrayAccess,
  input  wire                 arrayDone,
  // Code-space reads
  input  wire                 offchipFetch,
  input  wire [7:0]           arrayReadData,
  output wire [7:0]           codeReadData,
  // Array control
  output reg                  arrayStart,
  output reg  [7:0]           arrayCommand,
  output wire                 cpuStall
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [2:0] syncStage1_reg;
  reg [2:0] syncStage2_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      syncStage1_reg <= 3'h0;
      syncStage2_reg <= 3'h0;
    end else begin
      syncStage1_reg <= {inCircuitProgrammingMode, highVoltageError, resetInterruptedOp};
      syncStage2_reg <= syncStage1_reg;
    end
  end

  wire icpMode   = syncStage2_reg[2];
  wire hvError   = syncStage2_reg[1];
  wire resetLost = syncStage2_reg[0];

  // ----------------------------------------------------------------
  // Per-page guard decode
  // ----------------------------------------------------------------
  wire [PAGES-1:0] readGuardVec;
  wire [PAGES-1:0] writeGuardVec;
  wire [PAGES-1:0] eraseGuardVec;
  wire [PAGES-1:0] checksumBlockVec;

  genvar g;
  generate
    for (g = 0; g < PAGES; g = g + 1) begin : gPage
      ewgs_page_guard uGuard (
        .pageSecurity     (dataPageSecurity[8*g +: 8]),
        .offchipReadGuard (readGuardVec[g]),
        .pageWriteGuard   (writeGuardVec[g]),
        .runEraseGuard    (eraseGuardVec[g]),
        .checksumBlocked  (checksumBlockVec[g])
      );
    end
  endgenerate

  wire pageValid    = ({30'h0, pageSelect} < PAGES);
  wire selReadG     = pageValid & readGuardVec[pageSelect];
  wire selWriteG    = pageValid & writeGuardVec[pageSelect];
  wire selEraseG    = pageValid & eraseGuardVec[pageSelect];
  wire selChecksumB = pageValid & checksumBlockVec[pageSelect];
  wire anyReadG     = |readGuardVec;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg  faultFlag_reg;
  reg  secViolFlag_reg;
  reg  accessBlockFlag_reg;
  reg  writeEnableFlag_reg;
  reg  busyFlag_reg;
  reg  unlockArmed_reg;

  reg  faultFlag_next;
  reg  secViolFlag_next;
  reg  accessBlockFlag_next;
  reg  writeEnableFlag_next;
  reg  busyFlag_next;
  reg  unlockArmed_next;
  reg  startArray;
  reg  violation;

  wire cmdWrite  = sfrWrite & (sfrAddr == `EWGS_ADDR_CTRL_STATUS);
  wire dataWrite = sfrWrite & (sfrAddr == `EWGS_ADDR_DATA_IN);
  wire forceWe   = userConfigByte[`EWGS_USER_CONFIG_BYTE_FORCE_WE] | icpMode;
  wire weEff     = writeEnableFlag_reg | forceWe;
  wire codeProt  = codeProtectByte[`EWGS_CODE_PROTECT_BYTE_PROTECT];

  // ----------------------------------------------------------------
  // Command decode and flag update
  // ----------------------------------------------------------------
  always @* begin
    faultFlag_next       = faultFlag_reg;
    secViolFlag_next     = secViolFlag_reg;
    accessBlockFlag_next = accessBlockFlag_reg;
    writeEnableFlag_next = writeEnableFlag_reg;
    busyFlag_next        = busyFlag_reg;
    unlockArmed_next     = unlockArmed_reg;
    startArray           = 1'b0;
    violation            = 1'b0;
    if (busyFlag_reg && arrayDone) begin
      busyFlag_next = 1'b0;
    end
    if (cmdWrite && !busyFlag_reg) begin
      faultFlag_next   = 1'b0;
      secViolFlag_next = 1'b0;
      unlockArmed_next = 1'b0;
      case (sfrWData)
        `EWGS_CMD_UNLOCK: begin
          unlockArmed_next = 1'b1;
        end
        `EWGS_CMD_LOCK: begin
          writeEnableFlag_next = 1'b0;
        end
        `EWGS_CMD_MAP: begin
          accessBlockFlag_next = 1'b1;
        end
        `EWGS_CMD_UNMAP: begin
          accessBlockFlag_next = 1'b0;
        end
        `EWGS_CMD_PROGRAM, `EWGS_CMD_ERASE_PROG: begin
          violation  = codeProt | selWriteG;
          startArray = ~violation & (icpMode | weEff);
        end
        `EWGS_CMD_GLOBAL_ERASE: begin
          violation  = anyReadG;
          startArray = ~violation & (icpMode | weEff);
        end
        `EWGS_CMD_PAGE_ERASE: begin
          violation  = selEraseG & ~icpMode;
          startArray = ~violation & (icpMode | weEff);
        end
        `EWGS_CMD_CHECKSUM: begin
          violation  = selChecksumB;
          startArray = ~violation;
        end
        default: begin
        end
      endcase
      secViolFlag_next = violation;
      if (startArray) begin
        busyFlag_next = 1'b1;
      end
    end else if (dataWrite) begin
      if (unlockArmed_reg && sfrWData == `EWGS_WE_KEY) begin
        writeEnableFlag_next = 1'b1;
      end
      unlockArmed_next = 1'b0;
    end
    if (arrayAccess && accessBlockFlag_reg) begin
      faultFlag_next = 1'b1;
    end
    if (resetLost || hvError) begin
      faultFlag_next = 1'b1;
    end
    if (forceWe) begin
      writeEnableFlag_next = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      faultFlag_reg       <= 1'b0;
      secViolFlag_reg     <= 1'b0;
      accessBlockFlag_reg <= 1'b0;
      writeEnableFlag_reg <= 1'b0;
      busyFlag_reg        <= 1'b0;
      unlockArmed_reg     <= 1'b0;
      arrayStart          <= 1'b0;
      arrayCommand        <= `EWGS_CTRL_RESET;
    end else begin
      faultFlag_reg       <= faultFlag_next;
      secViolFlag_reg     <= secViolFlag_next;
      accessBlockFlag_reg <= accessBlockFlag_next;
      writeEnableFlag_reg <= writeEnableFlag_next;
      busyFlag_reg        <= busyFlag_next;
      unlockArmed_reg     <= unlockArmed_next;
      arrayStart          <= startArray;
      if (startArray) begin
        arrayCommand <= sfrWData;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  reg [7:0] statusByte;

  always @* begin
    statusByte                       = 8'h00;
    statusByte[`EWGS_BIT_FAULT]    = faultFlag_reg;
    statusByte[`EWGS_BIT_SECVIOL]  = secViolFlag_reg;
    statusByte[`EWGS_BIT_ACCBLOCK] = accessBlockFlag_reg;
    statusByte[`EWGS_BIT_WRENABLE] = writeEnableFlag_reg;
    statusByte[`EWGS_BIT_BUSY]     = busyFlag_reg;
  end

  assign sfrRData     = (sfrAddr == `EWGS_ADDR_CTRL_STATUS) ? statusByte : 8'h00;
  assign cpuStall     = busyFlag_reg & ~icpMode;
  assign codeReadData = (offchipFetch && selReadG) ? `EWGS_BLANK_BYTE : arrayReadData;

endmodule // ewgs_write_guard

// ===== verif/ewgs_write_guard_sva.sv
// Assertion checker for the EEPROM write guard and status block.
// Assumes it is bound onto ewgs_write_guard and sees only its ports.
`timescale 1ns/1ps
module ewgs_write_guard_sva #(
  parameter PAGES = 3
) (
  // Clock and reset
  input logic                 clk,
  input logic                 rst,
  // Register port and configuration
  input logic [7:0]           sfrAddr,
  input logic                 sfrWrite,
  input logic [7:0]           sfrWData,
  input logic [7:0]           sfrRData,
  input logic [1:0]           pageSelect,
  input logic [7:0]           userConfigByte,
  input logic [7:0]           codeProtectByte,
  input logic [8*PAGES-1:0]   dataPageSecurity,
  input logic                 inCircuitProgrammingMode,
  // Array side
  input logic                 arrayDone,
  input logic                 offchipFetch,
  input logic [7:0]           codeReadData,
  input logic                 arrayStart,
  input logic                 cpuStall
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire isCtrl = sfrAddr == 8'he4;
  wire newCmd = sfrWrite && isCtrl && !sfrRData[7];

  a_start_pulse: assert property (arrayStart |=> !arrayStart)
    else $error("start pulse longer than one cycle");
  a_start_busy: assert property (arrayStart && isCtrl |-> sfrRData[7])
    else $error("array started without busy");
  a_stall_busy: assert property (isCtrl && cpuStall |-> sfrRData[7])
    else $error("stall without busy");
  a_done_clears: assert property (arrayDone |=> !isCtrl || !sfrRData[7])
    else $error("busy stays after done");
  a_cmd_clears: assert property (newCmd && sfrWData == 8'h00 |=> !isCtrl || !sfrRData[1])
    else $error("violation flag not cleared by command");
  a_lock_clears: assert property (
    newCmd && sfrWData == 8'h0b && !$past(userConfigByte[2], 2) && !$past(inCircuitProgrammingMode, 2)
    && !userConfigByte[2] && !inCircuitProgrammingMode |=> !isCtrl || !sfrRData[6])
    else $error("write enable not cleared by lock");
  a_prog_guard: assert property (
    newCmd && (sfrWData == 8'h68 || sfrWData == 8'h48) && pageSelect < PAGES
    && (codeProtectByte[0] || dataPageSecurity[8*pageSelect+1]) |=> (!arrayStart)[*2])
    else $error("guarded page program started");
  a_global_guard: assert property (
    newCmd && sfrWData == 8'h4a && |(dataPageSecurity & {PAGES{8'h01}}) |=> !isCtrl || sfrRData[1])
    else $error("global erase violation not flagged");
  a_key_sets: assert property (
    newCmd && sfrWData == 8'h08 ##1 sfrWrite && sfrAddr == 8'hf6 && sfrWData == 8'h96
    |=> !isCtrl || sfrRData[6])
    else $error("unlock pair did not set write enable");
  a_read_guard: assert property (
    offchipFetch && pageSelect < PAGES && dataPageSecurity[8*pageSelect] |-> codeReadData == 8'hff)
    else $error("guarded page readable off-chip");

  c_program: cover property (newCmd && sfrWData == 8'h68 ##[1:2] arrayStart);
  c_violation: cover property (isCtrl && sfrRData[1]);
  c_fault: cover property (isCtrl && sfrRData[0]);
endmodule // ewgs_write_guard_sva

bind ewgs_write_guard ewgs_write_guard_sva #(.PAGES(PAGES)) ewgs_write_guard_sva_i (.*);

// ===== verif/test_ewgs_write_guard.sv
// Self-checking bench for the EEPROM write guard and status block.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
module test_ewgs_write_guard;
  logic        clk, rst = 1, sfrWrite = 0, inCircuitProgrammingMode = 0, offchipFetch = 0;
  logic        resetInterruptedOp = 0, highVoltageError = 0, arrayAccess = 0, arrayDone = 0;
  logic [7:0]  sfrAddr = 8'he4, sfrWData = 8'h00, userConfigByte = 8'h00, codeProtectByte = 8'h00;
  logic [7:0]  arrayReadData = 8'h00, sfrRData, codeReadData, arrayCommand, cmd, sec;
  logic [1:0]  pageSelect = 2'h1;
  logic [23:0] dataPageSecurity = 24'h000000;
  logic        arrayStart, cpuStall, prot, sv, st;
  int          errors = 0, nChecks = 0, starts = 0, s0;
  // Rows: command, page security, code protect, violation, start
  logic [18:0] rows [12] = '{{8'h68, 8'h00, 3'b001}, {8'h68, 8'h02, 3'b010}, {8'h68, 8'h00, 3'b110},
    {8'h48, 8'h02, 3'b010}, {8'h48, 8'h00, 3'b001}, {8'h4a, 8'h01, 3'b010}, {8'h4a, 8'h00, 3'b001},
    {8'h33, 8'h04, 3'b010}, {8'h33, 8'h00, 3'b001}, {8'h1d, 8'h01, 3'b010}, {8'h1d, 8'h03, 3'b001},
    {8'h1d, 8'h00, 3'b001}};

  ewgs_write_guard #(.PAGES(3)) ewgs_write_guard_i (.*);

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (arrayStart === 1'b1) starts++;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task check(input logic [15:0] seen, exp);
    nChecks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clk);
    sfrWrite <= 1'b1;
    sfrAddr <= a;
    sfrWData <= d;
  endtask
  task idle(input int n);
    @(posedge clk);
    sfrWrite <= 1'b0;
    sfrAddr <= 8'he4;
    arrayDone <= 1'b0;
    arrayAccess <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task close_out;
    if (errors == 0 && nChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    close_out;
  end

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1 check(sfrRData, 8'h00);
    wr(8'he4, 8'h68); idle(2);
    check({starts[7:0], sfrRData}, 16'h0000);
    wr(8'he4, 8'h08); wr(8'hf6, 8'h55); wr(8'hf6, 8'h96); idle(2);
    check(sfrRData, 8'h00);
    wr(8'he4, 8'h08); wr(8'he4, 8'h09); wr(8'hf6, 8'h96); idle(2);
    check(sfrRData, 8'h10);
    @(posedge clk) arrayAccess <= 1'b1;
    idle(2);
    check(sfrRData, 8'h11);
    wr(8'he4, 8'h0a); wr(8'he4, 8'h08); wr(8'hf6, 8'h96); idle(2);
    check(sfrRData, 8'h40);
    foreach (rows[i]) begin
      {cmd, sec, prot, sv, st} = rows[i];
      dataPageSecurity <= {8'h00, sec, 8'h00};
      codeProtectByte <= {7'h00, prot};
      s0 = starts;
      wr(8'he4, cmd); idle(2);
      check({cpuStall, 7'(starts - s0), sfrRData}, {st, 6'h0, st, st, 5'h10, sv, 1'b0});
      if (st) begin
        check(arrayCommand, cmd);
        @(posedge clk) arrayDone <= 1'b1;
        idle(2);
        check(sfrRData, 8'h40);
      end
    end
    @(posedge clk) inCircuitProgrammingMode <= 1'b1;
    dataPageSecurity <= 24'h000400;
    idle(3);
    wr(8'he4, 8'h33); idle(2);
    check({cpuStall, sfrRData}, 16'h00c0);
    @(posedge clk) arrayDone <= 1'b1;
    inCircuitProgrammingMode <= 1'b0;
    idle(3);
    wr(8'he4, 8'h0b); idle(2);
    check(sfrRData, 8'h00);
    @(posedge clk) userConfigByte <= 8'h04;
    idle(3);
    check(sfrRData, 8'h40);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) {highVoltageError, resetInterruptedOp} <= 2'b01 << k;
      idle(3);
      @(posedge clk) {highVoltageError, resetInterruptedOp} <= 2'b00;
      idle(3);
      check(sfrRData[0], 1'b1);
      wr(8'he4, 8'h00); idle(2);
      check(sfrRData[0], 1'b0);
    end
    wr(8'he4, 8'h00); wr(8'hf6, 8'h3c); wr(8'he4, 8'h68); idle(2);
    check(sfrRData & 8'h0f, 8'h00);
    check(arrayCommand, 8'h68);
    @(posedge clk) arrayDone <= 1'b1;
    idle(2);
    @(posedge clk) offchipFetch <= 1'b1;
    arrayReadData <= 8'h5a;
    dataPageSecurity <= 24'h000100;
    #1 check(codeReadData, 8'hff);
    @(posedge clk) dataPageSecurity <= 24'h000000;
    #1 check(codeReadData, 8'h5a);
    @(posedge clk) userConfigByte <= 8'h00;
    wr(8'he4, 8'h08); wr(8'hf6, 8'h96); idle(1);
    check(sfrRData, 8'h40);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    #1 check(sfrRData, 8'h00);
    close_out;
  end
endmodule // test_ewgs_write_guard
